// File: src/mcsi_pkg.sv
/*
 * Constants for the master configuration, status and interrupt block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 16-bit register port with 12-bit byte addresses.
 */
package mcsi_pkg;

    // register byte offsets
    localparam logic [11:0] RESET_ID_OFS = 12'h000;
    localparam logic [11:0] MASTER_CFG_OFS = 12'h010;
    localparam logic [11:0] MASTER_STATUS_OFS = 12'h020;
    localparam logic [11:0] MASTER_MASK_OFS = 12'h024;
    localparam logic [11:0] LOOPBACK_STATUS_OFS = 12'h030;
    localparam logic [11:0] LOOPBACK_MASK_OFS = 12'h034;
    localparam logic [11:0] DMA_STATUS_OFS = 12'h040;
    localparam logic [11:0] DMA_MASK_OFS = 12'h044;

    // reset values
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [7:0] CHIP_REV_DEFAULT = 8'h5A; // arbitrary value

    // master configuration fields and the master reset bit
    localparam int RX_DMA_EN_BIT = 0;
    localparam int RX_THR_LSB = 1;
    localparam int TX_DMA_EN_BIT = 3;
    localparam int TX_THR_LSB = 4;
    localparam int ORIENT_BIT = 6;
    localparam int TESTER_SEL_LSB = 7;
    localparam int RX_PRIO_LSB = 12;
    localparam int TX_PRIO_LSB = 14;
    localparam int SW_RESET_BIT = 0;

    // burst length base and tester codes
    localparam logic [8:0] BURST_BASE_DWORDS = 9'h020;
    localparam logic [4:0] TESTER_HS_PORT0 = 5'h10;
    localparam logic [4:0] TESTER_HS_PORT1 = 5'h11;

    // priority group sizes per code
    localparam logic [6:0] PRIO_GRP_NONE = 7'h00;
    localparam logic [6:0] PRIO_GRP_2 = 7'h02;
    localparam logic [6:0] PRIO_GRP_16 = 7'h10;
    localparam logic [6:0] PRIO_GRP_64 = 7'h40;

    // master status bit positions
    localparam int SM_RX_ALIGN_BIT = 0;
    localparam int SM_TX_ALIGN_BIT = 1;
    localparam int SM_TESTER_BIT = 2;
    localparam int SM_PCI_SYS_BIT = 3;
    localparam int SM_PCI_PAR_BIT = 4;
    localparam int SM_LOCAL_ERR_BIT = 14;
    localparam int SM_LOCAL_IRQ_BIT = 15;

    // local ready timeout, in local clock periods
    localparam logic [3:0] LOCAL_READY_PERIODS = 4'h9;

endpackage : mcsi_pkg

// File: src/event_status.sv
/*
 * One clear-on-read status register with its companion mask register.
 * Assumes events are one-cycle or level signals on clk.
 */
`timescale 1ns/1ps
module event_status
    import mcsi_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic softRst,
    input wire logic [15:0] evt,
    input wire logic rdClr,
    input wire logic maskWe,
    input wire logic [15:0] maskWdata,
    output logic [15:0] status,
    output logic [15:0] mask,
    output logic irq
);
    logic [15:0] status_q;
    logic [15:0] mask_q;

    // sticky bits, a new event beats the read clear, masking never blocks
    always_ff @(posedge clk) begin
        if (!nrst || softRst) begin
            status_q <= REG_RESET;
        end else begin
            status_q <= (rdClr ? REG_RESET : status_q) | evt; // [R13] [R14] [R16]
        end
    end

    // per-bit interrupt mask
    always_ff @(posedge clk) begin
        if (!nrst || softRst) begin
            mask_q <= REG_RESET;
        end else if (maskWe) begin
            mask_q <= maskWdata; // [R16]
        end
    end

    assign status = status_q;
    assign mask = mask_q;
    assign irq = |(status_q & mask_q); // [R25]

    property p_evt_sets;
        @(posedge clk) disable iff (!nrst || softRst)
        (evt != 16'h0000) |=> ((status_q & $past(evt)) == $past(evt));
    endproperty
    a_evt_sets: assert property (p_evt_sets) else $error("event lost"); // [R13]

    property p_read_clears;
        @(posedge clk) disable iff (!nrst || softRst)
        (rdClr && evt == 16'h0000) |=> (status_q == 16'h0000);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // [R14]

endmodule : event_status

// File: src/master_config_status_interrupt.sv
/*
 * Master configuration, master reset, three status/mask register pairs
 * and interrupt outputs of a multichannel HDLC controller.
 * Assumes a simple 16-bit register port from the host bus interface,
 * events from logic on clk, and local bus pins from outside the domain.
 */
// Behaviour
// (R1) configuration register resets to zero and is fully read/write
// (R2) receive DMA moves nothing while its enable bit is zero
// (R3) host configures a DMA direction fully before enabling it
// (R4) receive throttle caps burst at 32, 64, 128 or 256 dwords
// (R5) transmit DMA moves nothing while its enable bit is zero
// (R6) transmit throttle caps burst with same encoding as receive
// (R7) orientation bit selects packet data byte order on the bus
// (R8) register and local bus accesses are always little-endian
// (R9) tester port select: ports 0-15, two high-speed codes, rest unused
// (R10) receive priority: round robin or decode channels 1-2, 1-16, 1-64; here code 0 (round robin) grants nothing
// (R11) transmit priority uses the same four codes and groups
// (R12) inside a decoded group the lower channel number wins
// (R13) each status bit sets when its event occurs
// (R14) reading a status register clears its set bits
// (R15) unmasked status raises bus interrupt, local one in config mode
// (R16) each status register has a per-bit mask; status sets regardless
// (R17) per-port alignment enables gate events into summary bits
// (R18) software polls up to 16 port registers to find alignment source
// (R19) tester reports sync change, bit error, counter overflow, each maskable
// (R20) bus and local bus events are always recorded; here local bus bits record only while bridgeMode is set
// (R21) bridge mode records local interrupt and local ready timing errors
// (R22) software ignores local status bits in configuration mode
// (R23) local error sets when ready is missing for nine local clocks
// (R24) software reset bit holds all other registers at zero
// (R25) interrupt is OR of status AND mask, drops once cleared
`timescale 1ns/1ps
module master_config_status_interrupt
    import mcsi_pkg::*;
#(
    parameter logic [7:0] CHIP_REV = CHIP_REV_DEFAULT // arbitrary value
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [11:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    input wire logic [15:0] rxAlignChange,
    input wire logic [15:0] rxAlignIrqEnable,
    input wire logic [15:0] txAlignChange,
    input wire logic [15:0] txAlignIrqEnable,
    input wire logic [2:0] testerEvent,
    input wire logic [2:0] testerEventMask,
    input wire logic pciSysError,
    input wire logic pciParityError,
    input wire logic [15:0] loopbackEvent,
    input wire logic [15:0] dmaEvent,
    input wire logic bridgeMode,
    input wire logic localAccessStart,
    input wire logic localInterruptN,
    input wire logic localReadyN,
    input wire logic localBusClock,
    input wire logic [63:0] rxChanReq,
    input wire logic [63:0] txChanReq,
    output logic rxDmaEnable,
    output logic [8:0] rxBurstMax,
    output logic txDmaEnable,
    output logic [8:0] txBurstMax,
    output logic packetByteSwap,
    output logic [3:0] testerPort,
    output logic testerHiSpeed,
    output logic testerValid,
    output logic [6:0] rxPrioGroup,
    output logic [6:0] txPrioGroup,
    output logic rxGrantValid,
    output logic [5:0] rxGrantIdx,
    output logic txGrantValid,
    output logic [5:0] txGrantIdx,
    output logic pciIrqN,
    output logic localIrqN
);

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic softRst_q;
    logic [15:0] mcfg_q;
    logic [15:0] regRdata_q;
    logic wrCfg;
    logic [15:0] smEvt;
    logic [15:0] smStatus, smMask, lbStatus, lbMask, dmStatus, dmMask;
    logic smIrq, lbIrq, dmIrq;
    logic configMode;
    assign wrCfg = regWr && !softRst_q;
    assign configMode = !bridgeMode;
    // master software reset bit, cleared only by the host or hard reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            softRst_q <= 1'b0;
        end else if (regWr && regAddr == RESET_ID_OFS) begin
            softRst_q <= regWdata[SW_RESET_BIT];
        end
    end
    // master configuration register
    always_ff @(posedge clk) begin
        if (!nrst || softRst_q) begin
            mcfg_q <= REG_RESET; // [R1] [R24]
        end else if (wrCfg && regAddr == MASTER_CFG_OFS) begin
            mcfg_q <= regWdata; // [R1]
        end
    end
    // registered read data; bit order is native, never swapped
    always_ff @(posedge clk) begin
        if (!nrst) begin
            regRdata_q <= REG_RESET;
        end else if (regRd) begin
            unique case (regAddr)
                RESET_ID_OFS: regRdata_q <= {CHIP_REV, 7'h00, softRst_q}; // [R8]
                MASTER_CFG_OFS: regRdata_q <= mcfg_q; // [R1] [R8]
                MASTER_STATUS_OFS: regRdata_q <= smStatus;
                MASTER_MASK_OFS: regRdata_q <= smMask;
                LOOPBACK_STATUS_OFS: regRdata_q <= lbStatus;
                LOOPBACK_MASK_OFS: regRdata_q <= lbMask;
                DMA_STATUS_OFS: regRdata_q <= dmStatus;
                DMA_MASK_OFS: regRdata_q <= dmMask;
                default: regRdata_q <= REG_RESET;
            endcase
        end
    end
    assign regRdata = regRdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // configuration decode

    logic [4:0] testerSel;
    assign testerSel = mcfg_q[TESTER_SEL_LSB +: 5];
    function automatic logic [6:0] prioGroup(input logic [1:0] code);
        unique case (code)
            2'b00: prioGroup = PRIO_GRP_NONE;
            2'b01: prioGroup = PRIO_GRP_2;
            2'b10: prioGroup = PRIO_GRP_16;
            2'b11: prioGroup = PRIO_GRP_64;
        endcase
    endfunction
    // enables, burst caps, byte order and priority groups
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rxDmaEnable <= 1'b0;
            txDmaEnable <= 1'b0;
            rxBurstMax <= BURST_BASE_DWORDS;
            txBurstMax <= BURST_BASE_DWORDS;
            packetByteSwap <= 1'b0;
            rxPrioGroup <= PRIO_GRP_NONE;
            txPrioGroup <= PRIO_GRP_NONE;
        end else begin
            rxDmaEnable <= mcfg_q[RX_DMA_EN_BIT]; // [R2]
            txDmaEnable <= mcfg_q[TX_DMA_EN_BIT]; // [R5]
            rxBurstMax <= BURST_BASE_DWORDS << mcfg_q[RX_THR_LSB +: 2]; // [R4]
            txBurstMax <= BURST_BASE_DWORDS << mcfg_q[TX_THR_LSB +: 2]; // [R6]
            packetByteSwap <= mcfg_q[ORIENT_BIT]; // [R7]
            rxPrioGroup <= prioGroup(mcfg_q[RX_PRIO_LSB +: 2]); // [R10]
            txPrioGroup <= prioGroup(mcfg_q[TX_PRIO_LSB +: 2]); // [R11]
        end
    end
    // tester port assignment; unused codes leave the tester unassigned
    always_ff @(posedge clk) begin
        if (!nrst) begin
            testerPort <= 4'h0;
            testerHiSpeed <= 1'b0;
            testerValid <= 1'b1;
        end else begin
            testerPort <= testerSel[3:0]; // [R9]
            testerHiSpeed <= testerSel[4];
            testerValid <= !testerSel[4] || testerSel == TESTER_HS_PORT0
                           || testerSel == TESTER_HS_PORT1; // [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // priority pick inside the decoded group: lowest channel first

    function automatic logic [6:0] pickLowest(input logic [63:0] req, input logic [6:0] grp);
        logic [6:0] res;
        res = 7'h00;
        for (int i = 63; i >= 0; i--) begin
            if (req[i] && 7'(i) < grp) begin
                res = {1'b1, 6'(i)}; // [R12]
            end
        end
        pickLowest = res;
    endfunction
    logic [6:0] rxPick, txPick;
    assign rxPick = pickLowest(rxChanReq, prioGroup(mcfg_q[RX_PRIO_LSB +: 2]));
    assign txPick = pickLowest(txChanReq, prioGroup(mcfg_q[TX_PRIO_LSB +: 2]));
    // grants are withheld while the direction's DMA is disabled
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rxGrantValid <= 1'b0;
            rxGrantIdx <= 6'h00;
            txGrantValid <= 1'b0;
            txGrantIdx <= 6'h00;
        end else begin
            rxGrantValid <= rxPick[6] && mcfg_q[RX_DMA_EN_BIT]; // [R2] [R12]
            rxGrantIdx <= rxPick[5:0];
            txGrantValid <= txPick[6] && mcfg_q[TX_DMA_EN_BIT]; // [R5] [R12]
            txGrantIdx <= txPick[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // local bus pins: synchronisers and ready timeout

    logic lintS1_q, lintS2_q, lrdyS1_q, lrdyS2_q, lclkS1_q, lclkS2_q, lclkPrev_q;
    logic lclkRise;
    logic accessPending_q;
    logic [3:0] periodCnt_q;
    logic localErrEvt;
    // two stages each; the edge detector compares the second stage with its delayed copy lclkPrev_q
    always_ff @(posedge clk) begin
        if (!nrst) begin
            {lintS1_q, lintS2_q} <= 2'b11;
            {lrdyS1_q, lrdyS2_q} <= 2'b11;
            {lclkS1_q, lclkS2_q, lclkPrev_q} <= 3'b000;
        end else begin
            {lintS2_q, lintS1_q} <= {lintS1_q, localInterruptN};
            {lrdyS2_q, lrdyS1_q} <= {lrdyS1_q, localReadyN};
            {lclkPrev_q, lclkS2_q, lclkS1_q} <= {lclkS2_q, lclkS1_q, localBusClock};
        end
    end
    assign lclkRise = lclkS2_q && !lclkPrev_q;
    // count local clock periods of a pending bridge access without ready
    always_ff @(posedge clk) begin
        if (!nrst || softRst_q) begin
            accessPending_q <= 1'b0;
            periodCnt_q <= 4'h0;
        end else if (localAccessStart && bridgeMode) begin
            accessPending_q <= 1'b1;
            periodCnt_q <= 4'h0;
        end else if (accessPending_q && (!lrdyS2_q || localErrEvt)) begin
            accessPending_q <= 1'b0;
        end else if (accessPending_q && lclkRise) begin
            periodCnt_q <= periodCnt_q + 4'h1;
        end
    end
    assign localErrEvt = accessPending_q && lrdyS2_q
                         && periodCnt_q == LOCAL_READY_PERIODS; // [R23]

    ////////////////////////////////////////////////////////////////////////////
    // status registers

    // master status events; bus events have no suppressing control
    always_comb begin
        smEvt = 16'h0000;
        smEvt[SM_RX_ALIGN_BIT] = |(rxAlignChange & rxAlignIrqEnable); // [R17]
        smEvt[SM_TX_ALIGN_BIT] = |(txAlignChange & txAlignIrqEnable); // [R17]
        smEvt[SM_TESTER_BIT] = |(testerEvent & ~testerEventMask); // [R19]
        smEvt[SM_PCI_SYS_BIT] = pciSysError; // [R20]
        smEvt[SM_PCI_PAR_BIT] = pciParityError; // [R20]
        smEvt[SM_LOCAL_ERR_BIT] = bridgeMode && localErrEvt; // [R21]
        smEvt[SM_LOCAL_IRQ_BIT] = bridgeMode && !lintS2_q; // [R21]
    end
    event_status u_masterStatus (
        .clk(clk), .nrst(nrst), .softRst(softRst_q), .evt(smEvt),
        .rdClr(regRd && regAddr == MASTER_STATUS_OFS),
        .maskWe(wrCfg && regAddr == MASTER_MASK_OFS), .maskWdata(regWdata),
        .status(smStatus), .mask(smMask), .irq(smIrq)
    );
    event_status u_loopbackStatus (
        .clk(clk), .nrst(nrst), .softRst(softRst_q), .evt(loopbackEvent),
        .rdClr(regRd && regAddr == LOOPBACK_STATUS_OFS),
        .maskWe(wrCfg && regAddr == LOOPBACK_MASK_OFS), .maskWdata(regWdata),
        .status(lbStatus), .mask(lbMask), .irq(lbIrq)
    );
    event_status u_dmaStatus (
        .clk(clk), .nrst(nrst), .softRst(softRst_q), .evt(dmaEvent),
        .rdClr(regRd && regAddr == DMA_STATUS_OFS),
        .maskWe(wrCfg && regAddr == DMA_MASK_OFS), .maskWdata(regWdata),
        .status(dmStatus), .mask(dmMask), .irq(dmIrq)
    );
    // interrupt pins, active low, registered
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pciIrqN <= 1'b1;
            localIrqN <= 1'b1;
        end else begin
            pciIrqN <= !(smIrq || lbIrq || dmIrq); // [R15] [R25]
            localIrqN <= !(configMode && (smIrq || lbIrq || dmIrq)); // [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_cfg_reset;
        @(posedge clk) !nrst |=> (mcfg_q == 16'h0000);
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero"); // [R1]
    property p_rx_gate;
        @(posedge clk) disable iff (!nrst) !rxDmaEnable |-> !rxGrantValid;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx grant while disabled"); // [R2]
    property p_tx_gate;
        @(posedge clk) disable iff (!nrst) !txDmaEnable |-> !txGrantValid;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx grant while disabled"); // [R5]
    property p_rx_burst;
        @(posedge clk) disable iff (!nrst)
        $past(nrst) |-> rxBurstMax == (9'h020 << $past(mcfg_q[2:1]));
    endproperty
    a_rx_burst: assert property (p_rx_burst) else $error("rx burst cap wrong"); // [R4]
    property p_tx_burst;
        @(posedge clk) disable iff (!nrst)
        $past(nrst) |-> txBurstMax == (9'h020 << $past(mcfg_q[5:4]));
    endproperty
    a_tx_burst: assert property (p_tx_burst) else $error("tx burst cap wrong"); // [R6]
    property p_tester_valid;
        @(posedge clk) disable iff (!nrst)
        $past(nrst) |-> testerValid == ($past(mcfg_q[11:7]) < 5'h12);
    endproperty
    a_tester_valid: assert property (p_tester_valid) else $error("tester code"); // [R9]
    property p_soft_reset;
        @(posedge clk) disable iff (!nrst) softRst_q |=> (mcfg_q == 16'h0000);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset ignored"); // [R24]
    property p_pci_irq;
        @(posedge clk) disable iff (!nrst)
        (smStatus & smMask) != 16'h0000 |=> !pciIrqN;
    endproperty
    a_pci_irq: assert property (p_pci_irq) else $error("irq not raised"); // [R15]
    property p_local_irq;
        @(posedge clk) disable iff (!nrst) bridgeMode |=> localIrqN;
    endproperty
    a_local_irq: assert property (p_local_irq) else $error("local irq in bridge"); // [R15]
    property p_timeout;
        @(posedge clk) disable iff (!nrst || softRst_q)
        (bridgeMode && localErrEvt) |=> smStatus[14];
    endproperty
    a_timeout: assert property (p_timeout) else $error("local error missed"); // [R23]

endmodule : master_config_status_interrupt

// File: dv/host_model.sv
/*
 * Host model: single reads and writes on the register port.
 * Assumes read data is registered at the strobe's sampling edge.
 */
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    input wire logic [15:0] regRdata,
    output logic [11:0] regAddr,
    output logic regWr,
    output logic regRd,
    output logic [15:0] regWdata
);
    // idle bus at time zero
    initial {regAddr, regWr, regRd, regWdata} = 30'h0;

    ////////////////////////////////////////////////////////////////////
    // one-cycle write strobe; data shows its inverse once released
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regWdata = d;
        regWr = 1'b1;
        @(posedge clk);
        #1;
        regWr = 1'b0;
        regWdata = ~d;
    endtask : wr

    // one-cycle read strobe; data is taken after the sampling edge
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regRd = 1'b1;
        @(posedge clk);
        #1;
        regRd = 1'b0;
        d = regRdata;
    endtask : rd
endmodule : host_model

// File: dv/master_config_status_interrupt_tb_top.sv
/*
 * Self-checking bench for the master configuration and status block.
 * Assumes the host model drives the register port.
 */
`timescale 1ns/1ps
module master_config_status_interrupt_tb_top;
    import mcsi_pkg::*;
    logic clk = 1'b0, nrst = 1'b0;
    logic [11:0] regAddr;
    logic regWr, regRd;
    logic [15:0] regWdata, regRdata, d;
    logic [15:0] rxAlignChange = '0, rxAlignIrqEnable = '0;
    logic [15:0] txAlignChange = '0, txAlignIrqEnable = '0;
    logic [2:0] testerEvent = '0, testerEventMask = '0;
    logic pciSysError = 0, pciParityError = 0, bridgeMode = 0, localAccessStart = 0;
    logic localInterruptN = 1, localReadyN = 1, localBusClock = 0;
    logic [15:0] loopbackEvent = '0, dmaEvent = '0;
    logic [63:0] rxChanReq = '0, txChanReq = '0;
    logic rxDmaEnable, txDmaEnable, packetByteSwap, testerHiSpeed, testerValid;
    logic [8:0] rxBurstMax, txBurstMax;
    logic [3:0] testerPort;
    logic [6:0] rxPrioGroup, txPrioGroup;
    logic rxGrantValid, txGrantValid, pciIrqN, localIrqN;
    logic [5:0] rxGrantIdx, txGrantIdx;
    int error_cnt = 0, n_tests = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    host_model host (.clk(clk), .regRdata(regRdata), .regAddr(regAddr), .regWr(regWr),
        .regRd(regRd), .regWdata(regWdata));

    master_config_status_interrupt uut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
        .regWr(regWr), .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
        .rxAlignChange(rxAlignChange), .rxAlignIrqEnable(rxAlignIrqEnable),
        .txAlignChange(txAlignChange), .txAlignIrqEnable(txAlignIrqEnable),
        .testerEvent(testerEvent), .testerEventMask(testerEventMask),
        .pciSysError(pciSysError), .pciParityError(pciParityError),
        .loopbackEvent(loopbackEvent), .dmaEvent(dmaEvent), .bridgeMode(bridgeMode),
        .localAccessStart(localAccessStart), .localInterruptN(localInterruptN),
        .localReadyN(localReadyN), .localBusClock(localBusClock), .rxChanReq(rxChanReq),
        .txChanReq(txChanReq), .rxDmaEnable(rxDmaEnable), .rxBurstMax(rxBurstMax),
        .txDmaEnable(txDmaEnable), .txBurstMax(txBurstMax), .packetByteSwap(packetByteSwap),
        .testerPort(testerPort), .testerHiSpeed(testerHiSpeed), .testerValid(testerValid),
        .rxPrioGroup(rxPrioGroup), .txPrioGroup(txPrioGroup), .rxGrantValid(rxGrantValid),
        .rxGrantIdx(rxGrantIdx), .txGrantValid(txGrantValid), .txGrantIdx(txGrantIdx),
        .pciIrqN(pciIrqN), .localIrqN(localIrqN));

    ////////////////////////////////////////////////////////////////////
    // compare, count and report
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // n edges on, then the input skew
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic finish_test;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // bounded wait for the bus interrupt to drop low
    task automatic wait_irq;
        int k;
        for (k = 0; k < 8 && pciIrqN !== 1'b0; k++) tick(1);
        if (pciIrqN !== 1'b0) begin
            chk("irq timeout", 16'h0000, 16'h0001);
            finish_test();
        end
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////
    // reset values, throttle codes, enables and byte order
    task automatic sc_cfg;
        logic [15:0] v;
        host.rd(MASTER_CFG_OFS, d);
        chk("cfg reset", REG_RESET, d);
        chk("irq idle", 16'h0001, {15'h0000, pciIrqN});
        for (int i = 0; i < 4; i++) begin
            v = 16'((i << 1) | (i << 4) | ((i & 1) << 6));
            host.wr(MASTER_CFG_OFS, v);
            tick(1);
            chk("dma off", 16'h0000, {14'h0000, rxDmaEnable, txDmaEnable});
            host.wr(MASTER_CFG_OFS, v | 16'h0009);
            tick(1);
            chk("rx burst", 16'(BURST_BASE_DWORDS << i), {7'h00, rxBurstMax});
            chk("tx burst", 16'(BURST_BASE_DWORDS << i), {7'h00, txBurstMax});
            chk("swap", 16'(i & 1), {15'h0000, packetByteSwap});
            chk("dma on", 16'h0003, {14'h0000, rxDmaEnable, txDmaEnable});
            host.rd(MASTER_CFG_OFS, d);
            chk("cfg rd", v | 16'h0009, d);
        end
    endtask : sc_cfg

    // tester port decode over boundary codes
    task automatic sc_tester;
        logic [4:0] c[5] = '{5'h00, 5'h0F, TESTER_HS_PORT0, TESTER_HS_PORT1, 5'h12};
        for (int i = 0; i < 5; i++) begin
            host.wr(MASTER_CFG_OFS, {4'h0, c[i], 7'h00});
            tick(1);
            chk("tst valid", 16'(c[i] < 5'h12), {15'h0000, testerValid});
            if (c[i] < 5'h12) chk("port", 16'(c[i]), {11'h000, testerHiSpeed, testerPort});
        end
    endtask : sc_tester

    // priority groups and lowest-channel grant
    task automatic sc_prio;
        logic [6:0] g[4] = '{PRIO_GRP_NONE, PRIO_GRP_2, PRIO_GRP_16, PRIO_GRP_64};
        rxChanReq = 64'h0000_0000_0000_0006;
        txChanReq = 64'h0001_0000_0000_8000;
        for (int i = 0; i < 4; i++) begin
            host.wr(MASTER_CFG_OFS, 16'((i << 12) | (i << 14) | 16'h0009));
            tick(3);
            chk("rx grp", {9'h000, g[i]}, {9'h000, rxPrioGroup});
            chk("tx grp", {9'h000, g[i]}, {9'h000, txPrioGroup});
            chk("rx gnt", i > 0 ? 16'h0041 : 16'h0000,
                {9'h000, rxGrantValid, i > 0 ? rxGrantIdx : 6'h00});
            chk("tx gnt", i > 1 ? 16'h004F : 16'h0000,
                {9'h000, txGrantValid, i > 1 ? txGrantIdx : 6'h00});
        end
        host.wr(MASTER_CFG_OFS, 16'hF000);
        tick(3);
        chk("gnt dma off", 16'h0000, {14'h0000, rxGrantValid, txGrantValid});
    endtask : sc_prio

    // clear on read, masking, gating and interrupt outputs
    task automatic sc_status;
        host.wr(MASTER_MASK_OFS, 16'h0000);
        pciSysError = 1;
        tick(1);
        pciSysError = 0;
        tick(3);
        chk("masked irq", 16'h0001, {15'h0000, pciIrqN});
        host.rd(MASTER_STATUS_OFS, d);
        chk("sm set", 16'h0001 << SM_PCI_SYS_BIT, d & 16'h3FFF);
        host.rd(MASTER_STATUS_OFS, d);
        chk("sm clr", 16'h0000, d & 16'h3FFF);
        host.wr(MASTER_MASK_OFS, 16'h0018);
        pciParityError = 1;
        tick(1);
        pciParityError = 0;
        wait_irq();
        tick(1);
        chk("irq both", 16'h0000, {14'h0000, pciIrqN, localIrqN});
        host.rd(MASTER_STATUS_OFS, d);
        tick(2);
        chk("irq drop", 16'h0003, {14'h0000, pciIrqN, localIrqN});
        testerEventMask = 3'h7;
        testerEvent = 3'h7;
        rxAlignChange = 16'h0100;
        tick(1);
        testerEvent = 3'h0;
        rxAlignChange = 16'h0000;
        tick(3);
        host.rd(MASTER_STATUS_OFS, d);
        chk("gated", 16'h0000, d & 16'h3FFF);
        testerEventMask = 3'h5;
        rxAlignIrqEnable = 16'h0100;
        testerEvent = 3'h2;
        rxAlignChange = 16'h0100;
        tick(1);
        testerEvent = 3'h0;
        rxAlignChange = 16'h0000;
        tick(3);
        host.rd(MASTER_STATUS_OFS, d);
        chk("ungated", 16'h0005, d & 16'h3FFF);
        dmaEvent = 16'h8001;
        loopbackEvent = 16'h4002;
        tick(1);
        dmaEvent = 16'h0000;
        loopbackEvent = 16'h0000;
        tick(3);
        host.rd(DMA_STATUS_OFS, d);
        chk("dma st", 16'h8001, d);
        host.rd(LOOPBACK_STATUS_OFS, d);
        chk("lpb st", 16'h4002, d);
        bridgeMode = 1;
        localInterruptN = 0;
        localAccessStart = 1;
        tick(2);
        localInterruptN = 1;
        localAccessStart = 0;
        repeat (20) begin
            tick(2);
            localBusClock = ~localBusClock;
        end
        host.rd(MASTER_STATUS_OFS, d);
        chk("local int", 16'hC000, d);
        bridgeMode = 0;
    endtask : sc_status

    // software reset holds registers at zero until released
    task automatic sc_swreset;
        host.wr(MASTER_CFG_OFS, 16'h00FF);
        host.wr(RESET_ID_OFS, 16'h0001);
        host.rd(MASTER_CFG_OFS, d);
        chk("swrst cfg", REG_RESET, d);
        host.wr(MASTER_CFG_OFS, 16'h1234);
        host.wr(RESET_ID_OFS, 16'h0000);
        host.rd(MASTER_CFG_OFS, d);
        chk("swrst wr", REG_RESET, d);
        host.rd(RESET_ID_OFS, d);
        chk("id", {CHIP_REV_DEFAULT, 8'h00}, d);
        host.rd(12'h7FC, d);
        chk("unmapped", 16'h0000, d);
    endtask : sc_swreset

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        tick(12);
        nrst = 1'b1;
        sc_cfg();
        sc_tester();
        sc_prio();
        sc_status();
        sc_swreset();
        finish_test();
    end
endmodule : master_config_status_interrupt_tb_top
